// ==== src/dpsram_host_consts.svh ====
/*
  Constants for the host side of a dual-port static RAM access port:
  widths, idle pin levels and timing counts.
  Assumes a 10 MHz controller clock; all times are in nanoseconds.
*/
`ifndef DPSRAM_HOST_CONSTS_SVH
`define DPSRAM_HOST_CONSTS_SVH

`define ADDR_W 19
`define DATA_W 18

// Idle levels of the strobes and selects
`define LVL_INACTIVE_N 1'h1
`define LVL_INACTIVE_HIGH 1'h0

`define T_CLK_NS 100
// Read access from address or select
`define T_ACCESS_NS 15
// Collision flag release to valid data
`define T_FLAG_DATA_NS 15
// Write pulse width
`define T_WP_NS 12
// Write cycle time, address stable per write
`define T_WC_NS 15

// Least times round up to whole cycles
`define CYC_UP(t) (((t) + `T_CLK_NS - 1) / `T_CLK_NS)
`define ACC_CYC `CYC_UP(`T_ACCESS_NS)
`define FLAG_CYC `CYC_UP(`T_FLAG_DATA_NS)
`define RD_CYC ((`FLAG_CYC > `ACC_CYC) ? `FLAG_CYC : `ACC_CYC)
`define WP_CYC `CYC_UP(`T_WP_NS)
`define WC_CYC `CYC_UP(`T_WC_NS)
`define BEAT_CYC ((`WC_CYC > `WP_CYC) ? `WC_CYC : `WP_CYC)
`define SYNC_STAGES 2

`endif

// ==== src/dpsram_host_pkg.sv ====
/*
  Types for the dual-port static RAM host controller: request, pin group,
  operation and state encodings.
  Assumes dpsram_host_consts.svh is on the include path.
*/
package dpsram_host_pkg;
`include "dpsram_host_consts.svh"

  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] data_t;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_BURST = 3'h2,
    OP_SEM_READ = 3'h3,
    OP_SEM_WRITE = 3'h4
  } op_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_READ = 3'h1,
    S_WSETUP = 3'h2,
    S_WPULSE = 3'h3,
    S_WEND = 3'h4
  } state_e;

  typedef struct packed {
    op_e op;
    addr_t addr;
    data_t data;
    logic upperGateN;
    logic lowerGateN;
  } req_s;

  typedef struct packed {
    logic chipSelectActiveLowN;
    logic chipSelectActiveHigh;
    logic flagSelectN;
    logic upperByteGateN;
    logic lowerByteGateN;
    logic writeStrobeN;
    logic outputGateN;
    addr_t addr;
  } pins_s;

endpackage

// ==== src/dpsram_sync.sv ====
/*
  Two-flop synchroniser for a bus of pin inputs.
  Assumes the bus is only read as a whole once it has settled.
*/
`timescale 1ns/1ns
`default_nettype none

module dpsram_sync #(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule

`default_nettype wire

// ==== src/dpsram_host_port.sv ====
/*
  Host controller for one port of an asynchronous dual-port static RAM:
  array reads and writes, address-paced burst writes, semaphore reads
  and writes, all on a 10 MHz clock.
  Assumes the data pins are merged from dataOut/dataOe outside, and that
  requests come from logic on clk.
*/
// Functional notes
// - Read data is trusted only after the collision flag wait.
// - Normal writes keep strobe or select high while the address moves.
// - Host never drives data while the device may drive the pins.
// - Output gate during a strobe write needs a longer pulse.
// - Burst data changes only together with the address.
// - Setup and recovery wrap every write, including write after write, but not the beats inside a burst.
// - Address stays stable a full write cycle per burst write.
// - Burst writes may repeat any number of times.
// - Semaphore cycles keep low select high and high select low.
`timescale 1ns/1ns
`default_nettype none
`include "dpsram_host_consts.svh"

module dpsram_host_port
  import dpsram_host_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire req_s req,
  input wire logic reqValid,
  output logic reqReady,
  output data_t rspData,
  output logic rspValid,
  output pins_s pins,
  input wire data_t dataIn,
  output data_t dataOut,
  output logic dataOe
);

  localparam int READ_WAIT = `RD_CYC + `SYNC_STAGES - 1;
  localparam int RD_LAT = READ_WAIT + 1;
  localparam int BEAT = `BEAT_CYC;
  localparam pins_s PINS_IDLE = '{
    chipSelectActiveLowN: `LVL_INACTIVE_N,
    chipSelectActiveHigh: `LVL_INACTIVE_HIGH,
    flagSelectN: `LVL_INACTIVE_N,
    upperByteGateN: `LVL_INACTIVE_N,
    lowerByteGateN: `LVL_INACTIVE_N,
    writeStrobeN: `LVL_INACTIVE_N,
    outputGateN: `LVL_INACTIVE_N,
    addr: '0
  };

  state_e stateReg, stateNext;
  logic [3:0] cntReg, cntNext;
  op_e opReg, opNext;
  pins_s pinsReg, pinsNext;
  data_t dataOutReg, dataOutNext;
  logic dataOeReg, dataOeNext;
  logic readyReg, readyNext;
  data_t rspDataReg;
  logic rspValidReg;
  logic captureNow;
  req_s pendReg, pendNext;
  logic pendValidReg, pendValidNext;
  data_t dataSync;
  logic take;
  logic start;
  req_s src;

  dpsram_sync #(.WIDTH(`DATA_W)) dataSyncInst (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn(dataIn),
    .syncOut(dataSync)
  );

  assign take = reqValid && readyReg;
  assign start = pendValidReg || take;
  assign src = pendValidReg ? pendReg : req;

  // Selects and gates for one access; outputs and strobe stay off
  function automatic pins_s accessPins(req_s r);
    pins_s p;
    p = PINS_IDLE;
    p.addr = r.addr;
    if (r.op == OP_SEM_READ || r.op == OP_SEM_WRITE)
    begin
      p.flagSelectN = 1'b0;
      p.upperByteGateN = 1'b0;
      p.lowerByteGateN = 1'b0;
    end
    else
    begin
      p.chipSelectActiveLowN = 1'b0;
      p.chipSelectActiveHigh = 1'b1;
      p.upperByteGateN = r.upperGateN;
      p.lowerByteGateN = r.lowerGateN;
    end
    return p;
  endfunction

  always_comb
  begin
    stateNext = stateReg;
    cntNext = cntReg;
    opNext = opReg;
    pinsNext = pinsReg;
    dataOutNext = dataOutReg;
    dataOeNext = dataOeReg;
    captureNow = 1'b0;
    pendNext = pendReg;
    pendValidNext = pendValidReg;
    case (stateReg)
      S_IDLE:
      begin
        pinsNext = PINS_IDLE;
        pinsNext.addr = pinsReg.addr;
        dataOeNext = 1'b0;
        if (start)
        begin
          pendValidNext = 1'b0;
          opNext = src.op;
          pinsNext = accessPins(src);
          dataOutNext = src.data;
          if (src.op == OP_READ || src.op == OP_SEM_READ)
          begin
            pinsNext.outputGateN = 1'b0;
            cntNext = 4'(READ_WAIT);
            stateNext = S_READ;
          end
          else
          begin
            stateNext = S_WSETUP;
          end
        end
      end
      S_READ:
      begin
        if (cntReg == 4'h0)
        begin
          captureNow = 1'b1;
          pinsNext = PINS_IDLE;
          pinsNext.addr = pinsReg.addr;
          stateNext = S_IDLE;
        end
        else
        begin
          cntNext = cntReg - 4'h1;
        end
      end
      S_WSETUP:
      begin
        // Output gate stays high, so the device is off the pins
        pinsNext.writeStrobeN = 1'b0;
        dataOeNext = 1'b1;
        cntNext = 4'(BEAT - 1);
        stateNext = S_WPULSE;
      end
      S_WPULSE:
      begin
        if (cntReg != 4'h0)
        begin
          cntNext = cntReg - 4'h1;
        end
        else if (take && opReg == OP_BURST && req.op == OP_BURST)
        begin
          // Next beat: address and data move together, strobe stays low
          pinsNext.addr = req.addr;
          pinsNext.upperByteGateN = req.upperGateN;
          pinsNext.lowerByteGateN = req.lowerGateN;
          dataOutNext = req.data;
          cntNext = 4'(BEAT - 1);
        end
        else
        begin
          if (take)
          begin
            pendNext = req;
            pendValidNext = 1'b1;
          end
          pinsNext.writeStrobeN = 1'b1;
          stateNext = S_WEND;
        end
      end
      S_WEND:
      begin
        // Data held one cycle past the strobe rise
        pinsNext = PINS_IDLE;
        pinsNext.addr = pinsReg.addr;
        dataOeNext = 1'b0;
        stateNext = S_IDLE;
      end
      default:
      begin
        pinsNext = PINS_IDLE;
        dataOeNext = 1'b0;
        stateNext = S_IDLE;
      end
    endcase
    readyNext = (stateNext == S_IDLE && !pendValidNext) ||
      (stateNext == S_WPULSE && cntNext == 4'h0 && opNext == OP_BURST);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stateReg <= S_IDLE;
      cntReg <= 4'h0;
      opReg <= OP_READ;
      pendReg <= '0;
      pendValidReg <= 1'b0;
    end
    else
    begin
      stateReg <= stateNext;
      cntReg <= cntNext;
      opReg <= opNext;
      pendReg <= pendNext;
      pendValidReg <= pendValidNext;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pinsReg <= PINS_IDLE;
      dataOutReg <= '0;
      dataOeReg <= 1'b0;
    end
    else
    begin
      pinsReg <= pinsNext;
      dataOutReg <= dataOutNext;
      dataOeReg <= dataOeNext;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      readyReg <= 1'b0;
      rspDataReg <= '0;
      rspValidReg <= 1'b0;
    end
    else
    begin
      readyReg <= readyNext;
      rspValidReg <= captureNow;
      if (captureNow)
      begin
        rspDataReg <= dataSync;
      end
    end
  end

  assign reqReady = readyReg;
  assign rspData = rspDataReg;
  assign rspValid = rspValidReg;
  assign pins = pinsReg;
  assign dataOut = dataOutReg;
  assign dataOe = dataOeReg;

  // Cycles the current address has stood on the pins, for the beat check
  logic [7:0] addrHeldReg;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      addrHeldReg <= 8'h00;
    end
    else if (pinsNext.addr != pinsReg.addr)
    begin
      addrHeldReg <= 8'h01;
    end
    else if (addrHeldReg != 8'hff)
    begin
      addrHeldReg <= addrHeldReg + 8'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  addr_move_guard_a: assert property (
    $changed(pinsReg.addr) |-> $past(pinsReg.writeStrobeN) ||
      (stateReg == S_WPULSE && $past(stateReg) == S_WPULSE))
    else $error("address moved under a normal write strobe");
  no_drive_clash_a: assert property (
    dataOeReg |-> pinsReg.outputGateN && $past(pinsReg.outputGateN))
    else $error("data driven while device output gate active");
  gate_off_write_a: assert property (
    !pinsReg.writeStrobeN |-> pinsReg.outputGateN && dataOeReg)
    else $error("write strobe low with output gate active or no data");
  sem_selects_a: assert property (
    !pinsReg.flagSelectN |->
      pinsReg.chipSelectActiveLowN && !pinsReg.chipSelectActiveHigh)
    else $error("semaphore access with chip select active");
  array_selects_a: assert property (
    !pinsReg.chipSelectActiveLowN |-> pinsReg.flagSelectN &&
      pinsReg.chipSelectActiveHigh)
    else $error("array access with flag select active");
  burst_data_a: assert property (
    dataOeReg && $past(dataOeReg) && $changed(dataOutReg) |->
      $changed(pinsReg.addr) && !pinsReg.writeStrobeN)
    else $error("write data moved without an address change");
  beat_hold_a: assert property (
    $changed(pinsReg.addr) && !$past(pinsReg.writeStrobeN) |->
      $past(addrHeldReg) >= 8'(BEAT))
    else $error("burst address held less than a write cycle");
  read_latency_a: assert property (
    $fell(pinsReg.outputGateN) |-> ##RD_LAT rspValidReg)
    else $error("read answer not at the fixed latency");
  write_end_a: assert property (
    $rose(pinsReg.writeStrobeN) |=> !dataOeReg && pinsReg.outputGateN)
    else $error("write end did not release the data pins");

  read_seen_c: cover property ($fell(pinsReg.outputGateN) ##RD_LAT rspValidReg);
  write_seen_c: cover property ($fell(pinsReg.writeStrobeN) && pinsReg.flagSelectN);
  burst_seen_c: cover property (
    !pinsReg.writeStrobeN && $changed(pinsReg.addr) && $past(!pinsReg.writeStrobeN));
  sem_write_c: cover property ($fell(pinsReg.writeStrobeN) && !pinsReg.flagSelectN);

endmodule

`default_nettype wire

// ==== tb/dpsram_device_model.sv ====
/*
  Behavioural model of one asynchronous dual-port RAM port: a small
  array, eight semaphore flags and the data pin drivers.
  Assumes the bench merges the data bus from host and model drives.
*/
`timescale 1ns/1ns
`default_nettype none

module dpsram_device_model
  import dpsram_host_pkg::*;
(
  input wire pins_s pins,
  input wire logic hostOe,
  input wire data_t bus,
  output data_t devData,
  output logic clashSeen
);
  data_t mem [64];
  logic [7:0] flag_select;
  data_t held;
  data_t rdVal;
  logic combined;
  logic arraySel;
  logic semSel;
  logic rdOn;

  assign combined = !pins.chipSelectActiveLowN && pins.chipSelectActiveHigh;
  assign arraySel = combined && pins.flagSelectN;
  assign semSel = !combined && !pins.flagSelectN;
  // Drive only once every enabling condition holds; a strobe low keeps pins off
  assign rdOn = !pins.outputGateN && pins.writeStrobeN && (semSel || (arraySel &&
    (!pins.upperByteGateN || !pins.lowerByteGateN)));
  assign rdVal = semSel ? {$bits(data_t){flag_select[pins.addr[2:0]]}} :
    mem[pins.addr[5:0]];
  assign devData = rdOn ? rdVal : ~held;

  initial
  begin
    for (int i = 0; i < 64; i++)
    begin
      mem[i] = 18'h0_0000;
    end
    flag_select = 8'hFF;
    held = 18'h0_0000;
    clashSeen = 1'b0;
  end

  // Store during the overlap; an address change ends one write, starts the next
  always @*
  begin
    if (arraySel && !pins.writeStrobeN)
    begin
      if (!pins.lowerByteGateN)
        mem[pins.addr[5:0]][8:0] = bus[8:0];
      if (!pins.upperByteGateN)
        mem[pins.addr[5:0]][17:9] = bus[17:9];
    end
    if (semSel && !pins.writeStrobeN)
      flag_select[pins.addr[2:0]] = bus[0];
  end

  // A released bus shows the inverse of the last value the model drove
  always @*
  begin
    if (rdOn)
      held = rdVal;
  end

  always @*
  begin
    if (hostOe && rdOn)
      clashSeen = 1'b1;
  end
endmodule

`default_nettype wire

// ==== tb/test_dpsram_host_port.sv ====
/*
  Self-checking bench for the host port controller: array reads and
  writes, byte gates, address-paced bursts and semaphores.
  Assumes the device model file is compiled before this one.
*/
`timescale 1ns/1ns
`default_nettype none

module test_dpsram_host_port;
  import dpsram_host_pkg::*;
  logic clk;
  logic sys_rst;
  req_s req;
  logic reqValid;
  logic reqReady;
  data_t rspData;
  logic rspValid;
  pins_s pins;
  data_t dataIn;
  data_t dataOut;
  logic dataOe;
  data_t devData;
  logic clashSeen;
  int err_total;
  int cmp_count;

  assign dataIn = dataOe ? dataOut : devData;

  dpsram_host_port u_dpsram_host_port (.clk(clk), .sys_rst(sys_rst), .req(req),
    .reqValid(reqValid), .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid),
    .pins(pins), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
  dpsram_device_model u_dpsram_device_model (.pins(pins), .hostOe(dataOe),
    .bus(dataIn), .devData(devData), .clashSeen(clashSeen));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chkData(data_t got, data_t exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(logic got, logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Returns at the take edge, one edge later without keep; keep leaves it valid
  task automatic send(op_e op, addr_t a, data_t d, logic ug, logic lg, logic keep);
    int n;
    req <= '{op: op, addr: a, data: d, upperGateN: ug, lowerGateN: lg};
    reqValid <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (reqReady !== 1'b1 && n < 20);
    if (reqReady !== 1'b1)
    begin
      err_total++;
      $display("unexpected at %0t: request never taken", $time);
    end
    @(posedge clk);
    // An edge passes after dropping valid, so a next call never reassigns it
    if (!keep)
    begin
      reqValid <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Zero latency skips the timing check for queued requests
  task automatic readCheck(op_e op, addr_t a, data_t exp, int lat);
    int n;
    send(op, a, 18'h0_0000, 1'b0, 1'b0, 1'b0);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (rspValid !== 1'b1 && n < 20);
    chkBit(rspValid, 1'b1);
    if (lat != 0)
      chkBit(n == lat, 1'b1);
    chkData(rspData, exp);
    @(posedge clk);
  endtask

  task automatic testReset;
    @(negedge clk);
    chkBit(pins.chipSelectActiveLowN, 1'b1);
    chkBit(pins.chipSelectActiveHigh, 1'b0);
    chkBit(pins.writeStrobeN, 1'b1);
    chkBit(dataOe, 1'b0);
    @(posedge clk);
  endtask

  task automatic testWriteRead;
    send(OP_WRITE, 19'h0005, 18'h2_5A5A, 1'b0, 1'b0, 1'b0);
    send(OP_WRITE, 19'h0006, 18'h1_A5A5, 1'b0, 1'b0, 1'b0);
    readCheck(OP_READ, 19'h0005, 18'h2_5A5A, 3);
    readCheck(OP_READ, 19'h0006, 18'h1_A5A5, 3);
  endtask

  task automatic testByteGates;
    send(OP_WRITE, 19'h0009, 18'h3_FFFF, 1'b0, 1'b0, 1'b0);
    send(OP_WRITE, 19'h0009, 18'h0_0000, 1'b0, 1'b1, 1'b0);
    readCheck(OP_READ, 19'h0009, 18'h0_01FF, 3);
  endtask

  task automatic testBurst;
    for (int i = 0; i < 4; i++)
    begin
      send(OP_BURST, 19'h0020 + 19'(i), 18'h1_0000 + 18'(i * 3), 1'b0, 1'b0, 1'b1);
    end
    readCheck(OP_READ, 19'h0021, 18'h1_0003, 0);
    for (int i = 0; i < 4; i++)
    begin
      readCheck(OP_READ, 19'h0020 + 19'(i), 18'h1_0000 + 18'(i * 3), 3);
    end
  endtask

  task automatic testSemaphore;
    readCheck(OP_SEM_READ, 19'h0003, 18'h3_FFFF, 3);
    send(OP_SEM_WRITE, 19'h0003, 18'h3_FFFE, 1'b0, 1'b0, 1'b0);
    readCheck(OP_SEM_READ, 19'h0003, 18'h0_0000, 3);
    readCheck(OP_SEM_READ, 19'h0004, 18'h3_FFFF, 3);
    readCheck(OP_READ, 19'h0003, 18'h0_0000, 3);
  endtask

  initial
  begin
    err_total = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    reqValid = 1'b0;
    req = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    testReset;
    testWriteRead;
    testByteGates;
    testBurst;
    testSemaphore;
    chkBit(clashSeen, 1'b0);
    wrap_up;
  end

  initial
  begin
    repeat (2000) @(posedge clk);
    err_total++;
    wrap_up;
  end
endmodule

`default_nettype wire
